// ### pio_pkg.sv
// Purpose: shared constants for the parallel port latch block
// Assumes: eleven port groups, each held in a 16-bit slot
// Notes:   group index order is P0 low, P0 high, P1 low, P1 high, P2..P8
package pio_pkg;

    // group layout
    localparam int GRP_COUNT = 11;
    localparam int SLOT_W    = 16;
    localparam int PIN_W     = GRP_COUNT * SLOT_W;
    localparam int GRP_W     = 4;

    localparam logic [GRP_W-1:0] GRP_P3 = 4'h5;
    localparam logic [GRP_W-1:0] GRP_P5 = 4'h7;
    localparam int               P3_MISSING_BIT = 14;

    // bits that exist behind each group, index 0 is rightmost
    localparam logic [GRP_COUNT-1:0][SLOT_W-1:0] IMPL_MASK = {
        16'h00ff, 16'h00ff, 16'h00ff, 16'hffff, 16'h00ff, 16'hbfff,
        16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
    // bits with an output driver and direction control
    localparam logic [GRP_COUNT-1:0][SLOT_W-1:0] OUT_MASK = {
        16'h00ff, 16'h00ff, 16'h00ff, 16'h0000, 16'h00ff, 16'hbfff,
        16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
    // bits whose driver may be switched to open drain
    localparam logic [GRP_COUNT-1:0][SLOT_W-1:0] OD_MASK = {
        16'h00ff, 16'h00ff, 16'h00ff, 16'h0000, 16'h00ff, 16'hbfff,
        16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // register port
    localparam int ADDR_W = 7;
    localparam int OFS_W  = 3;
    localparam logic [OFS_W-1:0] OFS_DATA  = 3'h0;
    localparam logic [OFS_W-1:0] OFS_DIR   = 3'h1;
    localparam logic [OFS_W-1:0] OFS_OD    = 3'h2;
    localparam logic [OFS_W-1:0] OFS_LATCH = 3'h3;
    localparam logic [OFS_W-1:0] OFS_SET   = 3'h4;
    localparam logic [OFS_W-1:0] OFS_CLR   = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_THR = 7'h58;

    // threshold select, one bit per byte
    localparam int THR_W = 14;
    localparam logic [THR_W-1:0] THR_MASK  = 14'h3fff;
    localparam logic [THR_W-1:0] THR_RESET = 14'h0000;

    // state time divider
    localparam int DIV_W         = 8;
    localparam int STATE_DIV_DEF = 2;

endpackage : pio_pkg

// ### pio_in_sync.sv
// Purpose: pin synchroniser and input latch loaded once per state time
// Assumes: pins are asynchronous to SYS_CLK
// Notes:   latch holds between state ticks
`timescale 1ns/100ps
`default_nettype none
module pio_in_sync #(
    parameter int WIDTH = pio_pkg::PIN_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // sampling
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level
);

    typedef struct packed {
        logic [WIDTH-1:0] sync1;
        logic [WIDTH-1:0] sync2;
        logic [WIDTH-1:0] latch;
    } pio_sync_t;

    pio_sync_t st_reg;
    pio_sync_t st_next;

    always_comb
    begin
        st_next       = st_reg;
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;
        if (tick)
        begin
            st_next.latch = st_reg.sync2;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.latch;

    property p_sample;
        @(posedge clk) disable iff (rst)
        tick |=> (st_reg.latch == $past(st_reg.sync2));
    endproperty
    AST_SAMPLE_ON_TICK: assert property (p_sample)
        else $error("input latch missed a state tick");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !tick |=> $stable(st_reg.latch);
    endproperty
    AST_HOLD_BETWEEN_TICKS: assert property (p_hold)
        else $error("input latch changed between ticks");

endmodule : pio_in_sync
`default_nettype wire

// ### pio_port_top.sv
// Purpose: output latches, direction, driver mode and threshold control of the ports
// Assumes: pins are grouped in 16-bit slots, unused slot bits are never driven
// Notes:   set and clear aliases give a single-access read-modify-write
`timescale 1ns/100ps
`default_nettype none
// Operation
// - port 0 is two independent byte halves with own latches and direction
// - port 1 is two separately addressed byte halves, bidirectional
// - port 2 is a full 16-bit bidirectional port
// - port 3 has 15 lines; bit 14 has no logic behind it
// - port 4 is an 8-bit bidirectional port
// - port 5 is 16-bit input only, no drivers or direction
// - ports 6, 7 and 8 are 8-bit bidirectional ports
// - ports 2, 3, 4, 6, 7, 8 select push-pull or open drain per bit
// - every port has a software TTL or CMOS threshold select
// - every pin is sampled into its input latch once per state time
// - writing an input pin only updates its output latch
// - reading an input pin returns its input latch
// - modify on an input pin uses pin level, result goes to latch
// - direction 1 enables the driver so writes reach the pin
// - reading an output pin returns its output latch
// - modify on an output pin uses and updates the latch
// - after reset every pin is an input and drives nothing
// - threshold is per byte; ports 0, 1, 2, 3 and 5 use two bits
module pio_port_top #(
    parameter int STATE_DIV = pio_pkg::STATE_DIV_DEF
) (
    // clock and reset
    input  wire logic                       SYS_CLK,
    input  wire logic                       RST,
    // register port
    input  wire logic [pio_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [pio_pkg::SLOT_W-1:0] WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    output logic      [pio_pkg::SLOT_W-1:0] RDATA,
    // pins
    input  wire logic [pio_pkg::PIN_W-1:0]  PIN_IN,
    output logic      [pio_pkg::PIN_W-1:0]  PIN_OUT,
    output logic      [pio_pkg::PIN_W-1:0]  PIN_OE_N,
    output logic      [pio_pkg::PIN_W-1:0]  PIN_LEVEL,
    // input threshold select to pads, 1 = CMOS
    output logic      [pio_pkg::THR_W-1:0]  THRESH_CMOS
);

    localparam int GRP = pio_pkg::GRP_COUNT;
    localparam int SW  = pio_pkg::SLOT_W;

    typedef logic [GRP-1:0][SW-1:0] pio_slots_t;

    typedef struct packed {
        pio_slots_t                lat;
        pio_slots_t                dir;
        pio_slots_t                od;
        logic [pio_pkg::THR_W-1:0] thr;
        logic [pio_pkg::DIV_W-1:0] div;
        logic                      tick;
        pio_slots_t                pin_out;
        pio_slots_t                pin_oe_n;
        logic [SW-1:0]             rdata;
    } pio_state_t;

    pio_state_t                st_reg;
    pio_state_t                st_next;
    pio_slots_t                in_lat;
    logic [pio_pkg::GRP_W-1:0] grp;
    logic [pio_pkg::OFS_W-1:0] ofs;
    logic                      grp_ok;
    logic [SW-1:0]             view;

    // software view of a group: latch for outputs, pin for inputs
    function automatic logic [SW-1:0] pin_view(
        input logic [SW-1:0] lat,
        input logic [SW-1:0] dir,
        input logic [SW-1:0] inl,
        input logic [SW-1:0] mask
    );
        pin_view = ((lat & dir) | (inl & ~dir)) & mask;
    endfunction : pin_view

    pio_in_sync #(
        .WIDTH (pio_pkg::PIN_W)
    ) u_in_sync (
        .clk    (SYS_CLK),
        .rst    (RST),
        .tick   (st_reg.tick),
        .pin_in (PIN_IN),
        .level  (in_lat)
    );

    assign grp    = ADDR[pio_pkg::ADDR_W-1:pio_pkg::OFS_W];
    assign ofs    = ADDR[pio_pkg::OFS_W-1:0];
    assign grp_ok = (grp < pio_pkg::GRP_W'(GRP));
    // out of range groups see zero rather than an undefined slot
    assign view   = grp_ok ? pin_view(st_reg.lat[grp], st_reg.dir[grp], in_lat[grp],
                                      pio_pkg::IMPL_MASK[grp]) : '0;

    always_comb
    begin
        st_next       = st_reg;
        st_next.rdata = '0;

        // state time enable
        if (st_reg.div >= pio_pkg::DIV_W'(STATE_DIV - 1))
        begin
            st_next.div  = '0;
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.div  = st_reg.div + pio_pkg::DIV_W'(1);
            st_next.tick = 1'b0;
        end

        // writes; masks keep missing bits and port 5 outputs at zero
        if (WR && grp_ok)
        begin
            case (ofs)
                pio_pkg::OFS_DATA:
                begin
                    st_next.lat[grp] = WDATA & pio_pkg::OUT_MASK[grp];
                end
                pio_pkg::OFS_DIR:
                begin
                    st_next.dir[grp] = WDATA & pio_pkg::OUT_MASK[grp];
                end
                pio_pkg::OFS_OD:
                begin
                    st_next.od[grp] = WDATA & pio_pkg::OD_MASK[grp];
                end
                pio_pkg::OFS_SET:
                begin
                    st_next.lat[grp] = (view | WDATA) & pio_pkg::OUT_MASK[grp];
                end
                pio_pkg::OFS_CLR:
                begin
                    st_next.lat[grp] = (view & ~WDATA) & pio_pkg::OUT_MASK[grp];
                end
                default:
                begin
                    st_next.lat[grp] = st_reg.lat[grp];
                end
            endcase
        end
        else if (WR && (ADDR == pio_pkg::ADDR_THR))
        begin
            st_next.thr = WDATA[pio_pkg::THR_W-1:0] & pio_pkg::THR_MASK;
        end

        // reads answer in the next cycle; unmapped answers zero
        if (RD && grp_ok)
        begin
            case (ofs)
                pio_pkg::OFS_DATA:  st_next.rdata = view;
                pio_pkg::OFS_DIR:   st_next.rdata = st_reg.dir[grp];
                pio_pkg::OFS_OD:    st_next.rdata = st_reg.od[grp];
                pio_pkg::OFS_LATCH: st_next.rdata = st_reg.lat[grp];
                default:            st_next.rdata = '0;
            endcase
        end
        else if (RD && (ADDR == pio_pkg::ADDR_THR))
        begin
            st_next.rdata = {{(SW - pio_pkg::THR_W){1'b0}}, st_reg.thr};
        end

        // drivers built from next values so pins move with the latch
        for (int g = 0; g < GRP; g++)
        begin
            st_next.pin_out[g]  = st_next.lat[g];
            // open drain releases the pin for a one
            st_next.pin_oe_n[g] = ~(st_next.dir[g] & ~(st_next.od[g] & st_next.lat[g]));
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            st_reg          <= '0;
            st_reg.thr      <= pio_pkg::THR_RESET;
            st_reg.pin_oe_n <= '1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign RDATA       = st_reg.rdata;
    assign PIN_OUT     = st_reg.pin_out;
    assign PIN_OE_N    = st_reg.pin_oe_n;
    assign PIN_LEVEL   = in_lat;
    assign THRESH_CMOS = st_reg.thr;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    sequence s_wr_data;
        WR && grp_ok && (ofs == pio_pkg::OFS_DATA);
    endsequence

    sequence s_wr_set;
        WR && grp_ok && (ofs == pio_pkg::OFS_SET);
    endsequence

    sequence s_rd_data;
        RD && grp_ok && (ofs == pio_pkg::OFS_DATA);
    endsequence

    sequence s_wr_clr;
        WR && grp_ok && (ofs == pio_pkg::OFS_CLR);
    endsequence

    sequence s_wr_dir;
        WR && grp_ok && (ofs == pio_pkg::OFS_DIR);
    endsequence

    sequence s_wr_od;
        WR && grp_ok && (ofs == pio_pkg::OFS_OD);
    endsequence

    sequence s_rd_latch;
        RD && grp_ok && (ofs == pio_pkg::OFS_LATCH);
    endsequence

    // neither a group nor the threshold word
    sequence s_rd_unmapped;
        RD && !grp_ok && (ADDR != pio_pkg::ADDR_THR);
    endsequence

    sequence s_rd_thr;
        RD && (ADDR == pio_pkg::ADDR_THR);
    endsequence

    AST_INPUT_NEVER_DRIVEN: assert property (
        ~(|(~st_reg.pin_oe_n & ~st_reg.dir)))
        else $error("pin driven while its direction is input");

    AST_WRITE_TO_LATCH: assert property (
        s_wr_data |=> (st_reg.lat[$past(grp)] ==
                       ($past(WDATA) & pio_pkg::OUT_MASK[$past(grp)])))
        else $error("data write did not reach the output latch");

    AST_WRITE_TO_PIN: assert property (
        s_wr_data ##0 (st_reg.dir[grp] == pio_pkg::OUT_MASK[grp]) ##0 (st_reg.od[grp] == '0)
        |=> (~st_reg.pin_oe_n[$past(grp)] == pio_pkg::OUT_MASK[$past(grp)])
            && (st_reg.pin_out[$past(grp)] == ($past(WDATA) & pio_pkg::OUT_MASK[$past(grp)])))
        else $error("write to output pins did not drive them");

    AST_READ_VIEW: assert property (
        s_rd_data |=> (RDATA == $past(view)) ##1 (RDATA == '0 || $past(RD)))
        else $error("read data wrong or held too long");

    AST_READ_OUTPUT_LATCH: assert property (
        s_rd_data |=> ((RDATA & $past(st_reg.dir[grp])) ==
                       ($past(st_reg.lat[grp]) & $past(st_reg.dir[grp]))))
        else $error("output pin read did not return the latch");

    AST_SET_MODIFY: assert property (
        s_wr_set |=> (st_reg.lat[$past(grp)] ==
                      (($past(view) | $past(WDATA)) & pio_pkg::OUT_MASK[$past(grp)])))
        else $error("set alias used the wrong source");

    AST_P3_MISSING_LINE: assert property (
        !st_reg.lat[pio_pkg::GRP_P3][pio_pkg::P3_MISSING_BIT]
        && !st_reg.dir[pio_pkg::GRP_P3][pio_pkg::P3_MISSING_BIT]
        && st_reg.pin_oe_n[pio_pkg::GRP_P3][pio_pkg::P3_MISSING_BIT])
        else $error("missing port 3 line has state");

    AST_P5_INPUT_ONLY: assert property (
        (&st_reg.pin_oe_n[pio_pkg::GRP_P5]) && (st_reg.dir[pio_pkg::GRP_P5] == '0))
        else $error("input only port is driving");

    AST_OPEN_DRAIN_RELEASE: assert property (
        ~(|(~st_reg.pin_oe_n & st_reg.od & st_reg.lat)))
        else $error("open drain pin drove a one");

    AST_THR_WRITE: assert property (
        (WR && ADDR == pio_pkg::ADDR_THR) |=>
        (THRESH_CMOS == ($past(WDATA[pio_pkg::THR_W-1:0]) & pio_pkg::THR_MASK)) ##1
        $stable(THRESH_CMOS) || $past(WR))
        else $error("threshold select not taken");

    AST_TICK_SPACING: assert property (
        st_reg.tick |=> !st_reg.tick || (STATE_DIV <= 1))
        else $error("state ticks too close together");

    AST_CLR_MODIFY: assert property (
        s_wr_clr |=> (st_reg.lat[$past(grp)] ==
                      (($past(view) & ~$past(WDATA)) & pio_pkg::OUT_MASK[$past(grp)])))
        else $error("clear alias used the wrong source");

    AST_DIR_WRITE: assert property (
        s_wr_dir |=> (st_reg.dir[$past(grp)] ==
                      ($past(WDATA) & pio_pkg::OUT_MASK[$past(grp)])))
        else $error("direction write not taken or not masked");

    AST_OD_WRITE: assert property (
        s_wr_od |=> (st_reg.od[$past(grp)] ==
                     ($past(WDATA) & pio_pkg::OD_MASK[$past(grp)])))
        else $error("drive mode write not taken or not masked");

    AST_PUSH_PULL_DRIVES: assert property (
        ~(|(st_reg.pin_oe_n & st_reg.dir & ~st_reg.od)))
        else $error("push-pull output pin not driven");

    AST_READ_INPUT_PIN: assert property (
        s_rd_data |=> ((RDATA & ~$past(st_reg.dir[grp])) ==
                       ($past(in_lat[grp]) & ~$past(st_reg.dir[grp])
                        & pio_pkg::IMPL_MASK[$past(grp)])))
        else $error("input pin read did not return the sampled level");

    AST_READ_LATCH: assert property (
        s_rd_latch |=> (RDATA == $past(st_reg.lat[grp])))
        else $error("latch read did not return the output latch");

    AST_UNMAPPED_READ_ZERO: assert property (
        s_rd_unmapped |=> (RDATA == '0))
        else $error("unmapped read returned data");

    AST_THR_READ: assert property (
        s_rd_thr |=> (RDATA == {{(SW - pio_pkg::THR_W){1'b0}}, $past(st_reg.thr)}))
        else $error("threshold read back wrong");

    AST_THR_HOLD: assert property (
        !(WR && (ADDR == pio_pkg::ADDR_THR)) |=> $stable(THRESH_CMOS))
        else $error("threshold select moved without a write");

    // read data stands one cycle only, so stale words never leak
    AST_RDATA_IDLE_ZERO: assert property (
        !RD |=> (RDATA == '0))
        else $error("read data stood without a read");

    AST_P5_NO_LATCH: assert property (
        (st_reg.lat[pio_pkg::GRP_P5] == '0) && (st_reg.od[pio_pkg::GRP_P5] == '0))
        else $error("input only port holds output state");

    // kept outside the reset disable: the reset state itself is the rule
    AST_RESET_ALL_INPUTS: assert property (
        @(posedge SYS_CLK) disable iff (1'b0)
        $past(RST) |-> ((&st_reg.pin_oe_n) && (st_reg.dir == '0)))
        else $error("a pin direction or driver survived reset");

endmodule : pio_port_top
`default_nettype wire

// ### pio_pin_model.sv
// Purpose: board side of all port pins
// Assumes: every line carries a pull-up on the board
// Notes:   board drives only where the bench asks, device driver wins
`timescale 1ns/100ps
`default_nettype none
module pio_pin_model (
    // device side
    input  wire logic [pio_pkg::PIN_W-1:0] pin_out,
    input  wire logic [pio_pkg::PIN_W-1:0] pin_oe_n,
    // board stimulus
    input  wire logic [pio_pkg::PIN_W-1:0] ext_val,
    input  wire logic [pio_pkg::PIN_W-1:0] ext_en,
    // resolved level
    output logic      [pio_pkg::PIN_W-1:0] pin_in
);
    // released lines float up, so open drain gives a wired and
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en);
endmodule : pio_pin_model
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for the port latch block
// Assumes: short state time divider, board pull-ups on all lines
// Notes:   reads are checked by a monitor against a queue of expectations
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int DIV = 2;
    logic                        SYS_CLK, RST, WR, RD, rd_taken;
    logic [pio_pkg::ADDR_W-1:0]  ADDR;
    logic [15:0]                 WDATA, RDATA, e;
    logic [pio_pkg::PIN_W-1:0]   PIN_IN, PIN_OUT, PIN_OE_N, PIN_LEVEL, ext_val, ext_en;
    logic [pio_pkg::THR_W-1:0]   THRESH_CMOS;
    logic [15:0]                 expq[$];
    logic [31:0]                 seed;
    int                          bad_count, checks_done, g;

    pio_port_top #(.STATE_DIV(DIV)) u_pio_port_top (
        .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
        .PIN_LEVEL(PIN_LEVEL), .THRESH_CMOS(THRESH_CMOS));
    pio_pin_model u_pio_pin_model (
        .pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .ext_val(ext_val), .ext_en(ext_en),
        .pin_in(PIN_IN));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [6:0] ga(input logic [3:0] grp, input logic [2:0] o);
        return {grp, o};
    endfunction : ga

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic pin(input logic [15:0] got, input logic [15:0] exp, input string what);
        @(negedge SYS_CLK);
        chk(got, exp, what);
    endtask : pin

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge SYS_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge SYS_CLK);
        WR    <= 1'b0;
        // pin checks after a write must see the settled outputs
        @(negedge SYS_CLK);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [15:0] x);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        expq.push_back(x);
        @(posedge SYS_CLK);
        RD   <= 1'b0;
    endtask : rd

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end

    // read data stands only in the cycle after the strobe
    always @(posedge SYS_CLK) rd_taken <= RD;
    always @(negedge SYS_CLK)
        if (rd_taken === 1'b1)
        begin
            e = expq.pop_front();
            chk(RDATA, e, "read data");
        end

    initial
    begin
        repeat (20000) @(posedge SYS_CLK);
        bad_count++;
        $display("Error at %0t: run did not end in time", $time);
        tally_and_finish();
    end

    initial
    begin
        RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = '0; WDATA = '0;
        ext_val = '0; ext_en = '0; bad_count = 0; checks_done = 0; seed = 32'h26961188;
        repeat (10) @(posedge SYS_CLK);
        RST <= 1'b0;
        pin({15'h0, &PIN_OE_N}, 16'h0001, "drivers after reset");
        pin({2'h0, THRESH_CMOS}, 16'h0000, "threshold after reset");
        rd(ga(4'h4, pio_pkg::OFS_DIR), 16'h0000);
        $display("test reset done");
        // every group: implemented direction, drive mode and latch bits
        for (g = 0; g < pio_pkg::GRP_COUNT; g++)
        begin
            wr(ga(4'(g), pio_pkg::OFS_DIR), 16'hffff);
            wr(ga(4'(g), pio_pkg::OFS_OD), 16'hffff);
            wr(ga(4'(g), pio_pkg::OFS_DATA), 16'hffff);
            rd(ga(4'(g), pio_pkg::OFS_DIR), pio_pkg::OUT_MASK[g]);
            rd(ga(4'(g), pio_pkg::OFS_OD), pio_pkg::OD_MASK[g]);
            rd(ga(4'(g), pio_pkg::OFS_LATCH), pio_pkg::OUT_MASK[g]);
            wr(ga(4'(g), pio_pkg::OFS_DIR), 16'h0000);
            wr(ga(4'(g), pio_pkg::OFS_OD), 16'h0000);
            wr(ga(4'(g), pio_pkg::OFS_DATA), 16'h0000);
        end
        $display("test group layout done");
        // input pin: board drives, writes land in the latch only
        @(posedge SYS_CLK);
        ext_en[64 +: 16]  <= 16'hffff;
        ext_val[64 +: 16] <= 16'h1234;
        wr(ga(4'h4, pio_pkg::OFS_DATA), 16'h00ff);
        pin(PIN_OE_N[64 +: 16], 16'hffff, "input pin undriven");
        repeat (8) @(posedge SYS_CLK);
        rd(ga(4'h4, pio_pkg::OFS_DATA), 16'h1234);
        rd(ga(4'h4, pio_pkg::OFS_LATCH), 16'h00ff);
        wr(ga(4'h4, pio_pkg::OFS_SET), 16'h0001);
        rd(ga(4'h4, pio_pkg::OFS_LATCH), 16'h1235);
        $display("test input pin done");
        // output pin with random values
        @(posedge SYS_CLK);
        ext_en[64 +: 16] <= 16'h0000;
        wr(ga(4'h4, pio_pkg::OFS_DIR), 16'hffff);
        repeat (4)
        begin
            seed = lfsr(seed);
            wr(ga(4'h4, pio_pkg::OFS_DATA), seed[15:0]);
            pin(PIN_OUT[64 +: 16], seed[15:0], "pin value");
            pin(PIN_OE_N[64 +: 16], 16'h0000, "pin driven");
            rd(ga(4'h4, pio_pkg::OFS_DATA), seed[15:0]);
        end
        repeat (8) @(posedge SYS_CLK);
        pin(PIN_LEVEL[64 +: 16], seed[15:0], "output pin sampled");
        wr(ga(4'h4, pio_pkg::OFS_CLR), 16'h000f);
        rd(ga(4'h4, pio_pkg::OFS_DATA), seed[15:0] & 16'hfff0);
        pin(PIN_OUT[64 +: 16], seed[15:0] & 16'hfff0, "pin after clear");
        $display("test output pin done");
        // open drain on the 8-bit port: ones are released to the pull-up
        wr(ga(4'h6, pio_pkg::OFS_DIR), 16'h00ff);
        wr(ga(4'h6, pio_pkg::OFS_OD), 16'h00ff);
        wr(ga(4'h6, pio_pkg::OFS_DATA), 16'h000f);
        pin(PIN_OE_N[96 +: 16], 16'hff0f, "open drain enables");
        pin(PIN_IN[96 +: 16], 16'hff0f, "wired line level");
        $display("test open drain done");
        // threshold select and refused accesses
        wr(pio_pkg::ADDR_THR, 16'hffff);
        pin({2'h0, THRESH_CMOS}, 16'h3fff, "threshold select");
        rd(pio_pkg::ADDR_THR, 16'h3fff);
        rd(7'h7f, 16'h0000);
        repeat (4) @(posedge SYS_CLK);
        $display("test threshold done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
